// file: adc_calibration_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - Mode 001 starts self-calibration at the next conversion cycle start.
// - Self-cal offset phase shorts capacitor inputs for three periods, four in slave.
// - Self-cal then connects reference and runs full-scale for three periods.
// - Self and pseudo calibration end clear mode to 000, reconnect input.
// - Self-cal then fills filter three cycles, data-ready low on fourth.
// - Data-ready stays high through every calibration sequence except background, which asserts it as each gain phase and each later offset phase starts.
// - Mode 010 runs system offset calibration from next conversion cycle.
// - System offset and pseudo offset use the input, three periods, four slave.
// - After system offset or full-scale: clear mode, one conversion high, then low.
// - Mode 011 runs system full-scale on input, three periods, four slave.
// - Mode 100 runs pseudo system calibration: offset on input, then gain.
// - Pseudo calibration gain phase uses reference for three periods.
// - After pseudo calibration, three fill cycles high, then data-ready low.
// - Mode 101 enters background calibration until host writes another code.
// - Background: shorted offset three periods, reconnect, fill three, assert.
// - Background: gain on reference three, refill three, assert, repeat.
// - Background mode delivers valid data at one sixth of normal rate.
// - Results are held in offset and full-scale registers readable by host.
// - Host may write calibration registers; written values replace device results.
module adc_calibration_sequencer
    import cal_pkg::*;
#(
    parameter int unsigned CONV_CLKS = CONV_PERIOD_CLKS
)
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // Host mode write.
    input  wire logic        i_mode_we,
    input  wire logic [2:0]  i_mode_wdata,
    input  wire logic        i_slave_mode,
    input  wire logic [2:0]  i_oversample_rate_setting,
    // Host calibration register access.
    input  wire logic        i_host_ofs_we,
    input  wire logic        i_host_fs_we,
    input  wire logic [23:0] i_host_cal_data,
    // Modulator result feed.
    input  wire logic [23:0] i_conv_result,
    // Status and control outputs.
    output logic [2:0]       o_mode,
    output logic             o_result_valid_n,
    output logic [1:0]       o_cap_sel,
    output logic             o_calibrating,
    output logic [47:0]      o_cal_regs
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    localparam int CW = $clog2(CONV_CLKS + 1);

    typedef struct packed {
        logic [CW-1:0] clk_cnt;
        seq_state_e    state;
        logic [2:0]    mode;
        logic [2:0]    run_mode;
        logic [2:0]    per_cnt;
        logic [2:0]    per_tgt;
        logic          first_bg;
        logic          gain_next;
        logic          valid_n;
        cap_sel_e      cap;
        logic          ofs_cap;
        logic          fs_cap;
        logic          calib;
    } seq_s;

    seq_s s_q;
    seq_s s_d;
    logic conv_start;

    // Offset period count, longer in slave mode outside background.
    function automatic logic [2:0] ofs_len(input logic slave, input logic bg_first);
        ofs_len = (slave && !bg_first) ? CAL_PERIODS_SLAVE : CAL_PERIODS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    assign conv_start = (s_q.clk_cnt == CW'(CONV_CLKS - 1));

    always_comb begin
        s_d = s_q;
        s_d.ofs_cap = 1'b0;
        s_d.fs_cap = 1'b0;
        s_d.clk_cnt = conv_start ? '0 : s_q.clk_cnt + CW'(1);
        if (i_mode_we) begin
            s_d.mode = i_mode_wdata;
        end
        if (conv_start) begin
            s_d.valid_n = 1'b1;
            s_d.per_cnt = s_q.per_cnt + 3'h1;
            case (s_q.state)
                ST_NORMAL: begin
                    s_d.valid_n = 1'b0;
                    if (s_q.mode != MODE_NORMAL && s_q.mode <= MODE_BACKGND) begin
                        s_d.valid_n = 1'b1;
                        s_d.run_mode = s_q.mode;
                        s_d.per_cnt = 3'h1;
                        s_d.first_bg = 1'b1;
                        s_d.gain_next = 1'b0;
                        if (s_q.mode == MODE_SYS_FS) begin
                            s_d.state = ST_GAIN;
                            s_d.cap = CAP_INPUT;
                            s_d.per_tgt = ofs_len(i_slave_mode, 1'b0);
                        end else begin
                            s_d.state = ST_OFFSET;
                            s_d.per_tgt = ofs_len(i_slave_mode,
                                                  s_q.mode == MODE_BACKGND);
                            s_d.cap = (s_q.mode == MODE_SYS_OFS || s_q.mode == MODE_PSEUDO)
                                      ? CAP_INPUT : CAP_SHORTED;
                        end
                    end
                end
                ST_OFFSET: begin
                    if (s_q.per_cnt == s_q.per_tgt) begin
                        s_d.ofs_cap = 1'b1;
                        s_d.per_cnt = 3'h1;
                        if (s_q.run_mode == MODE_SYS_OFS) begin
                            s_d.mode = MODE_NORMAL;
                            s_d.state = ST_FILL;
                            s_d.per_tgt = SYS_FILL_PERIODS;
                        end else if (s_q.run_mode == MODE_BACKGND) begin
                            s_d.cap = CAP_INPUT;
                            s_d.state = ST_FILL;
                            s_d.per_tgt = FILL_PERIODS;
                            s_d.gain_next = 1'b1;
                            s_d.first_bg = 1'b0;
                        end else begin
                            s_d.cap = CAP_REF;
                            s_d.state = ST_GAIN;
                            s_d.per_tgt = CAL_PERIODS;
                        end
                    end
                end
                ST_GAIN: begin
                    if (s_q.per_cnt == s_q.per_tgt) begin
                        s_d.fs_cap = 1'b1;
                        s_d.per_cnt = 3'h1;
                        s_d.cap = CAP_INPUT;
                        s_d.state = ST_FILL;
                        if (s_q.run_mode == MODE_SYS_FS) begin
                            s_d.mode = MODE_NORMAL;
                            s_d.per_tgt = SYS_FILL_PERIODS;
                        end else begin
                            s_d.per_tgt = FILL_PERIODS;
                            s_d.gain_next = 1'b0;
                            if (s_q.run_mode != MODE_BACKGND) begin
                                s_d.mode = MODE_NORMAL;
                            end
                        end
                    end
                end
                ST_FILL: begin
                    if (s_q.per_cnt == s_q.per_tgt) begin
                        s_d.valid_n = 1'b0;
                        s_d.per_cnt = 3'h1;
                        if (s_q.run_mode == MODE_BACKGND) begin
                            s_d.state = s_q.gain_next ? ST_GAIN : ST_OFFSET;
                            s_d.cap = s_q.gain_next ? CAP_REF : CAP_SHORTED;
                            s_d.per_tgt = CAL_PERIODS;
                        end else begin
                            s_d.state = ST_NORMAL;
                            s_d.run_mode = MODE_NORMAL;
                        end
                    end
                end
                default: begin
                    s_d.state = ST_NORMAL;
                end
            endcase
        end
        // Leaving background acts last, so a write on a boundary still aborts.
        if (i_mode_we && i_mode_wdata != MODE_BACKGND && s_q.run_mode == MODE_BACKGND) begin
            s_d.state = ST_NORMAL;
            s_d.cap = CAP_INPUT;
            s_d.run_mode = MODE_NORMAL;
        end
        // The calibrating flag is registered together with the state.
        s_d.calib = (s_d.state == ST_OFFSET) || (s_d.state == ST_GAIN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            s_q <= '{clk_cnt: '0, state: ST_NORMAL, mode: MODE_NORMAL,
                     run_mode: MODE_NORMAL, per_cnt: 3'h0, per_tgt: 3'h0,
                     first_bg: 1'b0, gain_next: 1'b0, valid_n: 1'b1,
                     cap: CAP_INPUT, ofs_cap: 1'b0, fs_cap: 1'b0, calib: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration registers.

    cal_reg_pair u_regs (
        .i_core_clk    (i_core_clk),
        .i_reset       (i_reset),
        .i_ofs_capture (s_q.ofs_cap),
        .i_fs_capture  (s_q.fs_cap),
        .i_result      (i_conv_result),
        .i_host_ofs_we (i_host_ofs_we),
        .i_host_fs_we  (i_host_fs_we),
        .i_host_data   (i_host_cal_data),
        .o_regs        (o_cal_regs)
    );

    // Outputs straight from the state register.
    assign o_mode           = s_q.mode;
    assign o_result_valid_n = s_q.valid_n;
    assign o_cap_sel        = s_q.cap;
    assign o_calibrating    = s_q.calib;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_cal_high;
        @(posedge i_core_clk) disable iff (i_reset)
            ((s_q.state == ST_OFFSET || s_q.state == ST_GAIN) &&
             (s_q.run_mode != MODE_BACKGND || s_q.per_cnt != 3'h1)) |-> o_result_valid_n;
    endproperty
    a_cal_high: assert property (p_cal_high) else $error("data-ready low in cal");

    property p_short_in_self;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.state == ST_OFFSET && s_q.run_mode == MODE_SELF) |-> o_cap_sel == CAP_SHORTED;
    endproperty
    a_short_in_self: assert property (p_short_in_self) else $error("self offset not shorted");

    property p_gain_ref;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.state == ST_GAIN && s_q.run_mode != MODE_SYS_FS) |-> o_cap_sel == CAP_REF;
    endproperty
    a_gain_ref: assert property (p_gain_ref) else $error("gain not on reference");

    property p_start_self;
        @(posedge i_core_clk) disable iff (i_reset)
            (conv_start && s_q.state == ST_NORMAL && s_q.mode == MODE_SELF && !i_mode_we)
            |=> s_q.state == ST_OFFSET;
    endproperty
    a_start_self: assert property (p_start_self) else $error("self cal not started");

    property p_normal_valid;
        @(posedge i_core_clk) disable iff (i_reset)
            (conv_start && s_q.state == ST_NORMAL && s_q.mode == MODE_NORMAL && !i_mode_we)
            |=> !o_result_valid_n;
    endproperty
    a_normal_valid: assert property (p_normal_valid) else $error("no valid in normal");

    property p_fill_input;
        @(posedge i_core_clk) disable iff (i_reset)
            s_q.state == ST_FILL |-> o_cap_sel == CAP_INPUT;
    endproperty
    a_fill_input: assert property (p_fill_input) else $error("fill not on input");

    property p_mode_clear;
        @(posedge i_core_clk) disable iff (i_reset)
            ($rose(s_q.state == ST_FILL) && s_q.run_mode != MODE_BACKGND && !$past(i_mode_we))
            |-> o_mode == MODE_NORMAL;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");

    property p_bg_stays;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.run_mode == MODE_BACKGND && !i_mode_we) |=> o_mode == MODE_BACKGND;
    endproperty
    a_bg_stays: assert property (p_bg_stays) else $error("background mode left");

    property p_fill_high;
        @(posedge i_core_clk) disable iff (i_reset)
            s_q.state == ST_FILL |-> o_result_valid_n;
    endproperty
    a_fill_high: assert property (p_fill_high) else $error("data-ready low in fill");

    property p_bg_short;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.state == ST_OFFSET && s_q.run_mode == MODE_BACKGND)
            |-> o_cap_sel == CAP_SHORTED;
    endproperty
    a_bg_short: assert property (p_bg_short) else $error("bg offset not shorted");

    property p_sys_in;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.state == ST_OFFSET &&
             (s_q.run_mode == MODE_SYS_OFS || s_q.run_mode == MODE_PSEUDO))
            |-> o_cap_sel == CAP_INPUT;
    endproperty
    a_sys_in: assert property (p_sys_in) else $error("offset not on input");

    property p_fs_in;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.state == ST_GAIN && s_q.run_mode == MODE_SYS_FS)
            |-> o_cap_sel == CAP_INPUT;
    endproperty
    a_fs_in: assert property (p_fs_in) else $error("full-scale not on input");

    property p_per_bound;
        @(posedge i_core_clk) disable iff (i_reset)
            s_q.state != ST_NORMAL |-> s_q.per_cnt <= s_q.per_tgt;
    endproperty
    a_per_bound: assert property (p_per_bound) else $error("period count overrun");

    property p_valid_steady;
        @(posedge i_core_clk) disable iff (i_reset)
            !conv_start |=> $stable(o_result_valid_n);
    endproperty
    a_valid_steady: assert property (p_valid_steady) else $error("ready moved mid-period");

    property p_ofs_load;
        @(posedge i_core_clk) disable iff (i_reset)
            (s_q.ofs_cap && !i_host_ofs_we)
            |=> o_cal_regs[47:24] == $past(i_conv_result);
    endproperty
    a_ofs_load: assert property (p_ofs_load) else $error("offset result not held");

    property p_host_fs;
        @(posedge i_core_clk) disable iff (i_reset)
            i_host_fs_we
            |=> o_cal_regs[23:0] == $past(i_host_cal_data);
    endproperty
    a_host_fs: assert property (p_host_fs) else $error("host full-scale not loaded");

    property p_bg_gain;
        @(posedge i_core_clk) disable iff (i_reset)
            ($fell(o_result_valid_n) && s_q.run_mode == MODE_BACKGND)
            |-> o_calibrating;
    endproperty
    a_bg_gain: assert property (p_bg_gain) else $error("no cal with bg valid data");

    property p_start_bg;
        @(posedge i_core_clk) disable iff (i_reset)
            (conv_start && s_q.state == ST_NORMAL && s_q.mode == MODE_BACKGND)
            |=> (s_q.state == ST_OFFSET && s_q.run_mode == MODE_BACKGND);
    endproperty
    a_start_bg: assert property (p_start_bg) else $error("background not started");

endmodule

`default_nettype wire

// file: cal_pkg.sv
package cal_pkg;

    // Operation-mode codes.
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_SELF    = 3'h1;
    localparam logic [2:0] MODE_SYS_OFS = 3'h2;
    localparam logic [2:0] MODE_SYS_FS  = 3'h3;
    localparam logic [2:0] MODE_PSEUDO  = 3'h4;
    localparam logic [2:0] MODE_BACKGND = 3'h5;

    // Conversion-period counts.
    localparam logic [2:0] CAL_PERIODS       = 3'h3;
    localparam logic [2:0] CAL_PERIODS_SLAVE = 3'h4;
    localparam logic [2:0] FILL_PERIODS      = 3'h3;
    localparam logic [2:0] SYS_FILL_PERIODS  = 3'h1;

    // Default conversion period in core clocks.
    localparam int unsigned CONV_PERIOD_CLKS = 16;

    // Sampling capacitor source selection.
    typedef enum logic [1:0] {
        CAP_INPUT   = 2'h0,
        CAP_SHORTED = 2'h1,
        CAP_REF     = 2'h2
    } cap_sel_e;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_NORMAL  = 3'h0,
        ST_WAIT    = 3'h1,
        ST_OFFSET  = 3'h2,
        ST_GAIN    = 3'h3,
        ST_FILL    = 3'h4
    } seq_state_e;

    // Calibration result pair.
    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] fullscale;
    } cal_pair_s;

endpackage

// file: cal_reg_pair.sv
`timescale 1ns/10ps
`default_nettype none

// Holds offset and full-scale results; host writes override device results.
module cal_reg_pair
    import cal_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // Device result capture.
    input  wire logic        i_ofs_capture,
    input  wire logic        i_fs_capture,
    input  wire logic [23:0] i_result,
    // Host access.
    input  wire logic        i_host_ofs_we,
    input  wire logic        i_host_fs_we,
    input  wire logic [23:0] i_host_data,
    output logic      [47:0] o_regs
);

    cal_pair_s regs_q;
    cal_pair_s regs_d;

    // Host writes take priority, so loaded values replace computed ones.
    always_comb begin
        regs_d = regs_q;
        if (i_host_ofs_we) begin
            regs_d.offset = i_host_data;
        end else if (i_ofs_capture) begin
            regs_d.offset = i_result;
        end
        if (i_host_fs_we) begin
            regs_d.fullscale = i_host_data;
        end else if (i_fs_capture) begin
            regs_d.fullscale = i_result;
        end
    end

    // Register the pair.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    // Read data comes from the register.
    assign o_regs = regs_q;

endmodule

`default_nettype wire

// file: cal_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host-side model: writes the mode field and calibration registers, feeds results.
module cal_host_model (
    // Clock.
    input  wire logic        i_core_clk,
    // Mode and register writes.
    output logic             o_mode_we,
    output logic [2:0]       o_mode_wdata,
    output logic             o_slave_mode,
    output logic [2:0]       o_oversample_rate_setting,
    output logic             o_ofs_we,
    output logic             o_fs_we,
    output logic [23:0]      o_cal_data,
    // Modulator result feed.
    output logic [23:0]      o_conv_result
);
    // Idle values from time zero; the result feed is a fixed pattern.
    initial begin
        o_mode_we = 1'b0;
        o_mode_wdata = 3'h0;
        o_slave_mode = 1'b0;
        o_oversample_rate_setting = 3'h1;
        o_ofs_we = 1'b0;
        o_fs_we = 1'b0;
        o_cal_data = 24'h000000;
        o_conv_result = 24'h5A5A5A;
    end

    // One-cycle mode write, launched and ended off the falling edge.
    task automatic write_mode(input logic [2:0] code, input logic slave);
        @(negedge i_core_clk);
        o_slave_mode = slave;
        o_mode_wdata = code;
        o_mode_we = 1'b1;
        @(negedge i_core_clk);
        o_mode_we = 1'b0;
    endtask

    // One-cycle register write; released data shows its inverse afterwards.
    task automatic write_cal(input logic fs, input logic [23:0] data);
        @(negedge i_core_clk);
        o_cal_data = data;
        o_ofs_we = ~fs;
        o_fs_we = fs;
        @(negedge i_core_clk);
        o_ofs_we = 1'b0;
        o_fs_we = 1'b0;
        o_cal_data = ~data;
    endtask
endmodule

`default_nettype wire

// file: tb_adc_calibration_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module tb_adc_calibration_sequencer;
    import cal_pkg::*;

    localparam int unsigned C = 4;
    localparam logic [23:0] R = 24'h5A5A5A;

    logic        i_core_clk;
    logic        i_reset;
    logic        mode_we;
    logic [2:0]  mode_wdata;
    logic        slave;
    logic [2:0]  osr;
    logic        ofs_we;
    logic        fs_we;
    logic [23:0] cal_data;
    logic [23:0] conv_result;
    logic [2:0]  o_mode;
    logic        o_result_valid_n;
    logic [1:0]  o_cap_sel;
    logic        o_calibrating;
    logic [47:0] o_cal_regs;
    int          error_cnt = 0;
    int          checks = 0;

    cal_host_model i_cal_host_model (
        .i_core_clk               (i_core_clk),
        .o_mode_we                (mode_we),
        .o_mode_wdata             (mode_wdata),
        .o_slave_mode             (slave),
        .o_oversample_rate_setting(osr),
        .o_ofs_we                 (ofs_we),
        .o_fs_we                  (fs_we),
        .o_cal_data               (cal_data),
        .o_conv_result            (conv_result)
    );

    adc_calibration_sequencer #(.CONV_CLKS(C)) i_adc_calibration_sequencer (
        .i_core_clk               (i_core_clk),
        .i_reset                  (i_reset),
        .i_mode_we                (mode_we),
        .i_mode_wdata             (mode_wdata),
        .i_slave_mode             (slave),
        .i_oversample_rate_setting(osr),
        .i_host_ofs_we            (ofs_we),
        .i_host_fs_we             (fs_we),
        .i_host_cal_data          (cal_data),
        .i_conv_result            (conv_result),
        .o_mode                   (o_mode),
        .o_result_valid_n         (o_result_valid_n),
        .o_cap_sel                (o_cap_sel),
        .o_calibrating            (o_calibrating),
        .o_cal_regs               (o_cal_regs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock source.
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    // Compares one value and reports a difference at once.
    task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Waits on the falling edge until a signal reaches a level; returns cycles waited.
    task automatic wait_lvl(ref logic sig, input logic lvl, output int n);
        n = 0;
        while (sig !== lvl && n < 40 * C) begin
            @(negedge i_core_clk);
            n++;
        end
    endtask

    // Runs one one-shot calibration and measures its phases and fill.
    task automatic run_cal(input logic [2:0] code, input logic slv, input int ofs_p,
                           input int gain_p, input int fill_p, input logic [1:0] ofs_cap);
        int n;
        i_cal_host_model.write_mode(code, slv);
        wait_lvl(o_calibrating, 1'b1, n);
        check(48'(o_mode), 48'(code), "mode field at start");
        check(48'(o_cap_sel), 48'(ofs_cap), "offset phase source");
        n = 0;
        while (o_calibrating === 1'b1 && n < 40 * C) begin
            if (n == ofs_p * C) check(48'(o_cap_sel), 48'(CAP_REF), "gain phase source");
            check(48'(o_result_valid_n), 48'h1, "ready held during cal");
            @(negedge i_core_clk);
            n++;
        end
        check(48'(n), 48'((ofs_p + gain_p) * C), "cal length");
        check(48'(o_mode), 48'(MODE_NORMAL), "mode cleared");
        check(48'(o_cap_sel), 48'(CAP_INPUT), "input reconnected");
        wait_lvl(o_result_valid_n, 1'b0, n);
        check(48'(n), 48'(fill_p * C), "fill length");
        $display("test done: calibration mode %0d slave %0d", code, slv);
    endtask

    // Prints counts and verdict, then ends the run.
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung sequence.
    initial begin
        repeat (20000) @(posedge i_core_clk);
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end

    // Main test sequence.
    initial begin
        int n;
        i_reset = 1'b1;
        repeat (10) @(negedge i_core_clk);
        check(48'(o_result_valid_n), 48'h1, "ready in reset");
        check({45'h0, o_mode}, 48'h0, "mode in reset");
        check(o_cal_regs, 48'h0, "regs in reset");
        i_reset = 1'b0;
        wait_lvl(o_result_valid_n, 1'b0, n);
        check(48'(n <= 2 * C), 48'h1, "normal conversions report data");
        $display("test done: reset and normal");
        // Calibrate first after power-on.
        run_cal(MODE_SELF, 1'b0, 3, 3, 3, CAP_SHORTED);
        check(o_cal_regs, {R, R}, "self results");
        i_cal_host_model.write_cal(1'b0, 24'h123456);
        i_cal_host_model.write_cal(1'b1, 24'hFEDCBA);
        check(o_cal_regs, 48'h123456FEDCBA, "host written regs");
        $display("test done: host register write");
        // Offset is commanded before full-scale.
        run_cal(MODE_SYS_OFS, 1'b0, 3, 0, 1, CAP_INPUT);
        check(o_cal_regs, {R, 24'hFEDCBA}, "offset only updated");
        run_cal(MODE_SYS_FS, 1'b1, 4, 0, 1, CAP_INPUT);
        check(o_cal_regs, {R, R}, "full-scale updated");
        run_cal(MODE_SELF, 1'b1, 4, 3, 3, CAP_SHORTED);
        run_cal(MODE_PSEUDO, 1'b0, 3, 3, 3, CAP_INPUT);
        run_cal(MODE_PSEUDO, 1'b1, 4, 3, 3, CAP_INPUT);
        // Background mode: offset, fill, ready with gain, fill, ready with offset.
        i_cal_host_model.write_mode(MODE_BACKGND, 1'b1);
        wait_lvl(o_calibrating, 1'b1, n);
        check(48'(o_cap_sel), 48'(CAP_SHORTED), "bg offset source");
        wait_lvl(o_calibrating, 1'b0, n);
        check(48'(n), 48'(3 * C), "bg offset length");
        wait_lvl(o_result_valid_n, 1'b0, n);
        check(48'(n), 48'(3 * C), "bg fill length");
        check(48'(o_cap_sel), 48'(CAP_REF), "bg gain source");
        check(48'(o_calibrating), 48'h1, "bg gain running");
        wait_lvl(o_result_valid_n, 1'b1, n);
        check(48'(n), 48'(C), "ready low one period");
        wait_lvl(o_result_valid_n, 1'b0, n);
        check(48'(n), 48'(5 * C), "one result per six periods");
        check(48'(o_cap_sel), 48'(CAP_SHORTED), "bg offset repeats");
        check(48'(o_mode), 48'(MODE_BACKGND), "bg mode kept");
        i_cal_host_model.write_mode(MODE_NORMAL, 1'b0);
        repeat (C) @(negedge i_core_clk);
        check({45'h0, o_mode, o_calibrating, o_cap_sel}, 48'h0, "bg left");
        $display("test done: background");
        // Unused codes are stored but leave the converter idle.
        i_cal_host_model.write_mode(3'h6, 1'b0);
        repeat (3 * C) @(negedge i_core_clk);
        check({45'h0, o_mode}, 48'h6, "unused code stored");
        check({46'h0, o_calibrating, o_result_valid_n}, 48'h0, "unused code idles");
        $display("test done: unused code");
        print_verdict();
    end
endmodule

`default_nettype wire
